// [pkg/dbt_pkg.sv]
// Package for the debug breakpoint trigger: offsets, fields, types
package dbt_pkg;
  // Wishbone register byte offsets
  localparam logic [7:0] OFF_ATTR = 8'h00;
  localparam logic [7:0] OFF_LOW = 8'h04;
  localparam logic [7:0] OFF_HIGH = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_TRIG = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1c;
  localparam logic [7:0] OFF_SEL = 8'h20;
  localparam logic [7:0] OFF_WDATA = 8'h24;
  localparam logic [7:0] OFF_RDATA = 8'h28;
  // Attribute register fields
  localparam int DIR_MASK_BIT = 15;
  localparam int SIZE_MASK_LO = 13;
  localparam int TT_MASK_LO = 11;
  localparam int TM_MASK_LO = 8;
  localparam int DIR_BIT = 7;
  localparam int SIZE_LO = 5;
  localparam int TT_LO = 3;
  localparam int TM_LO = 0;
  // Size attribute encodings
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Trigger definition: address match case in bits 1:0, attribute enable in bit 2
  localparam logic [1:0] MATCH_OFF = 2'h0;
  localparam logic [1:0] MATCH_EQUAL = 2'h1;
  localparam logic [1:0] MATCH_INSIDE = 2'h2;
  localparam logic [1:0] MATCH_OUTSIDE = 2'h3;
  localparam int TRIG_ATTR_EN_BIT = 2;
  // Control: bit 0 selects first hardware revision sharing
  localparam int CTRL_SHARED_BIT = 0;
  // Debug commands
  localparam logic [15:0] CMD_WRITE_CREG = 16'h2880;
  localparam logic [15:0] CMD_READ_CREG = 16'h2980;
  localparam logic [15:0] CMD_MEM_READ = 16'h1900;
  localparam logic [15:0] CMD_MEM_WRITE = 16'h1800;
  // Control register selects for debug access
  localparam logic [11:0] CSEL_ATTR = 12'h00c;
  localparam logic [11:0] CSEL_LOW = 12'h00d;
  localparam logic [11:0] CSEL_HIGH = 12'h00e;
  localparam logic [11:0] CSEL_DATA = 12'h00f;
  localparam logic [11:0] CSEL_TRIG = 12'h007;
  // Reset values
  localparam logic [15:0] ATTR_RESET = 16'h0005;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic dir_read;
    logic [1:0] size;
    logic [1:0] ttype;
    logic [2:0] tmod;
  } dbt_xfer_t;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } dbt_long_t;
endpackage

// [design/dbt_trigger.sv]
// Breakpoint trigger with debug command port and Wishbone registers
`timescale 1ns/1ps
// Functional notes
// RQ1 - Shared mode: memory commands load their address into high address.
// RQ2 - Shared mode: debug write commands load data into data breakpoint.
// RQ3 - Shared mode: memory commands load attributes into attribute register.
// RQ4 - Attribute register compared with each bus transfer, used per trigger.
// RQ5 - Bit 15 set ignores read/write attribute in comparisons.
// RQ6 - Size mask bits 14-13 exclude matching size bits.
// RQ7 - Transfer type mask bits 12-11 exclude matching type bits.
// RQ8 - Modifier mask bits 10-8 exclude matching modifier bits.
// RQ9 - Bit 7 compared with the bus read/write direction.
// RQ10 - Bits 6-5 compared to bus size; 00 long, 01 byte, 10 word.
// RQ11 - Low and high addresses compared with every bus transfer address.
// RQ12 - Match cases: equal low, inside range inclusive, outside range.
// RQ13 - Low address register holds full 32-bit address.
// RQ14 - High address register holds full 32-bit inclusive upper bound.
// RQ15 - Read control register returns longword, upper half first.
// RQ16 - Write control register updates all 32 bits of selected register; attribute takes only bits 15-0, trigger definition only bits 3-0.
// RQ17 - Host sends write opcode 0x2880, zero word, select, then data; here select and data are written first, then the opcode with bit 31 set.
// RQ18 - Trigger pulse in cycle of transfer meeting address and attributes; TRIGGER_OUT is registered and pulses one cycle later.
module dbt_trigger (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Local bus transfer observed
  input wire dbt_pkg::dbt_xfer_t BUS_XFER_IN,
  // Trigger indication
  output logic TRIGGER_OUT
);
  logic [15:0] attr;
  logic [31:0] low_addr;
  logic [31:0] high_addr;
  logic [31:0] data_bkpt;
  logic [3:0] trig_def;
  logic [0:0] ctrl;
  logic [15:0] cmd;
  logic [31:0] csel;
  logic [31:0] cmd_wdata;
  dbt_pkg::dbt_long_t cmd_rdata;
  logic cmd_go;
  logic attr_hit;
  logic addr_hit;
  logic wb_req;
  logic wr_cmd;
  logic rd_cmd;
  logic mem_cmd;
  logic mem_wr;
  logic shared;
  logic [31:0] wb_mask;
  logic [31:0] next_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_reg(input logic [7:0] off);
    return wb_req && WB_WE_IN && WB_ADR_IN == off;
  endfunction

  assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign shared = ctrl[dbt_pkg::CTRL_SHARED_BIT];
  assign wr_cmd = cmd_go && cmd == dbt_pkg::CMD_WRITE_CREG;
  assign rd_cmd = cmd_go && cmd == dbt_pkg::CMD_READ_CREG;
  assign mem_wr = cmd_go && cmd == dbt_pkg::CMD_MEM_WRITE;
  assign mem_cmd = mem_wr || (cmd_go && cmd == dbt_pkg::CMD_MEM_READ);
  assign wb_mask = merge(32'h0, 32'hffff_ffff, WB_SEL_IN);

  // Attribute comparison with per-field masks
  always_comb begin
    logic [15:0] a;
    dbt_pkg::dbt_xfer_t x;
    a = attr;
    x = BUS_XFER_IN;
    attr_hit = 1'b1; // see RQ4
    if (!a[dbt_pkg::DIR_MASK_BIT] && a[dbt_pkg::DIR_BIT] != x.dir_read) begin
      attr_hit = 1'b0; // see RQ5, see RQ9
    end
    if (((a[dbt_pkg::SIZE_LO +: 2] ^ x.size) &
         ~a[dbt_pkg::SIZE_MASK_LO +: 2]) != 2'h0) begin
      attr_hit = 1'b0; // see RQ6, see RQ10
    end
    if (((a[dbt_pkg::TT_LO +: 2] ^ x.ttype) &
         ~a[dbt_pkg::TT_MASK_LO +: 2]) != 2'h0) begin
      attr_hit = 1'b0; // see RQ7
    end
    if (((a[dbt_pkg::TM_LO +: 3] ^ x.tmod) &
         ~a[dbt_pkg::TM_MASK_LO +: 3]) != 3'h0) begin
      attr_hit = 1'b0; // see RQ8
    end
  end

  // Address match case
  always_comb begin
    logic in_range;
    in_range = BUS_XFER_IN.addr >= low_addr && BUS_XFER_IN.addr <= high_addr;
    case (trig_def[1:0]) // see RQ11, see RQ12
      dbt_pkg::MATCH_EQUAL: addr_hit = BUS_XFER_IN.addr == low_addr;
      dbt_pkg::MATCH_INSIDE: addr_hit = in_range;
      dbt_pkg::MATCH_OUTSIDE: addr_hit = !in_range;
      default: addr_hit = 1'b0;
    endcase
  end

  // Trigger output, registered from the qualified transfer
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TRIGGER_OUT <= 1'b0;
    end else begin
      TRIGGER_OUT <= BUS_XFER_IN.valid && addr_hit && // see RQ18
        (attr_hit || !trig_def[dbt_pkg::TRIG_ATTR_EN_BIT]);
    end
  end

  // Attribute register
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      attr <= dbt_pkg::ATTR_RESET;
    end else if (mem_cmd && shared) begin
      attr <= csel[15:0]; // see RQ3
    end else if (wr_cmd && csel[11:0] == dbt_pkg::CSEL_ATTR) begin
      attr <= cmd_wdata[15:0]; // see RQ16
    end else if (is_reg(dbt_pkg::OFF_ATTR)) begin
      attr <= 16'(merge({16'h0, attr}, WB_DAT_IN, WB_SEL_IN));
    end
  end

  // Low address register
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      low_addr <= dbt_pkg::ZERO32;
    end else if (wr_cmd && csel[11:0] == dbt_pkg::CSEL_LOW) begin
      low_addr <= cmd_wdata; // see RQ13, see RQ16
    end else if (is_reg(dbt_pkg::OFF_LOW)) begin
      low_addr <= merge(low_addr, WB_DAT_IN, WB_SEL_IN);
    end
  end

  // High address register
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      high_addr <= dbt_pkg::ZERO32;
    end else if (mem_cmd && shared) begin
      high_addr <= cmd_wdata; // see RQ1
    end else if (wr_cmd && csel[11:0] == dbt_pkg::CSEL_HIGH) begin
      high_addr <= cmd_wdata; // see RQ14, see RQ16
    end else if (is_reg(dbt_pkg::OFF_HIGH)) begin
      high_addr <= merge(high_addr, WB_DAT_IN, WB_SEL_IN);
    end
  end

  // Data breakpoint register
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      data_bkpt <= dbt_pkg::ZERO32;
    end else if (shared && (mem_wr || wr_cmd)) begin
      data_bkpt <= cmd_wdata; // see RQ2
    end else if (wr_cmd && csel[11:0] == dbt_pkg::CSEL_DATA) begin
      data_bkpt <= cmd_wdata; // see RQ16
    end else if (is_reg(dbt_pkg::OFF_DATA)) begin
      data_bkpt <= merge(data_bkpt, WB_DAT_IN, WB_SEL_IN);
    end
  end

  // Trigger definition, control and command staging registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      trig_def <= 4'h0;
      ctrl <= 1'b0;
      cmd <= 16'h0;
      csel <= dbt_pkg::ZERO32;
      cmd_wdata <= dbt_pkg::ZERO32;
    end else begin
      if (wr_cmd && csel[11:0] == dbt_pkg::CSEL_TRIG) begin
        trig_def <= cmd_wdata[3:0];
      end else if (is_reg(dbt_pkg::OFF_TRIG)) begin
        trig_def <= 4'(merge({28'h0, trig_def}, WB_DAT_IN, WB_SEL_IN));
      end
      if (is_reg(dbt_pkg::OFF_CTRL)) begin
        ctrl <= 1'(merge({31'h0, ctrl}, WB_DAT_IN, WB_SEL_IN));
      end
      if (is_reg(dbt_pkg::OFF_CMD)) begin
        cmd <= 16'(merge({16'h0, cmd}, WB_DAT_IN, WB_SEL_IN));
      end
      if (is_reg(dbt_pkg::OFF_SEL)) begin
        csel <= merge(csel, WB_DAT_IN, WB_SEL_IN);
      end
      if (is_reg(dbt_pkg::OFF_WDATA)) begin
        cmd_wdata <= merge(cmd_wdata, WB_DAT_IN, WB_SEL_IN);
      end
    end
  end

  // Command launch pulse: write of bit 31 in command register word
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmd_go <= 1'b0;
    end else begin
      cmd_go <= is_reg(dbt_pkg::OFF_CMD) && WB_SEL_IN[3] && WB_DAT_IN[31];
    end
  end

  // Read control register result, upper half first
  always_comb begin
    case (csel[11:0])
      dbt_pkg::CSEL_ATTR: next_rdata = {16'h0, attr};
      dbt_pkg::CSEL_LOW: next_rdata = low_addr;
      dbt_pkg::CSEL_HIGH: next_rdata = high_addr;
      dbt_pkg::CSEL_DATA: next_rdata = data_bkpt;
      dbt_pkg::CSEL_TRIG: next_rdata = {28'h0, trig_def};
      default: next_rdata = dbt_pkg::ZERO32;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmd_rdata <= '0;
    end else if (rd_cmd) begin
      cmd_rdata <= next_rdata; // see RQ15
    end
  end

  // Wishbone answer: ack one cycle after request, unmapped reads zero
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= dbt_pkg::ZERO32;
    end else begin
      WB_ACK_OUT <= wb_req;
      if (wb_req && !WB_WE_IN) begin
        case (WB_ADR_IN)
          dbt_pkg::OFF_ATTR: WB_DAT_OUT <= {16'h0, attr};
          dbt_pkg::OFF_LOW: WB_DAT_OUT <= low_addr;
          dbt_pkg::OFF_HIGH: WB_DAT_OUT <= high_addr;
          dbt_pkg::OFF_DATA: WB_DAT_OUT <= data_bkpt;
          dbt_pkg::OFF_TRIG: WB_DAT_OUT <= {28'h0, trig_def};
          dbt_pkg::OFF_CTRL: WB_DAT_OUT <= {31'h0, ctrl};
          dbt_pkg::OFF_STAT: WB_DAT_OUT <= {30'h0, attr_hit, addr_hit};
          dbt_pkg::OFF_CMD: WB_DAT_OUT <= {16'h0, cmd};
          dbt_pkg::OFF_SEL: WB_DAT_OUT <= csel;
          dbt_pkg::OFF_WDATA: WB_DAT_OUT <= cmd_wdata;
          dbt_pkg::OFF_RDATA: WB_DAT_OUT <= cmd_rdata & wb_mask;
          default: WB_DAT_OUT <= dbt_pkg::ZERO32;
        endcase
      end
    end
  end

  // Assertions
  trig_equal_a: assert property ( // see RQ12
    @(posedge CLK_IN) disable iff (RST_IN)
    (BUS_XFER_IN.valid && trig_def == {2'h0, dbt_pkg::MATCH_EQUAL} &&
     BUS_XFER_IN.addr == low_addr) |=> TRIGGER_OUT)
    else $error("equal match missed");
  trig_needs_valid_a: assert property ( // see RQ18
    @(posedge CLK_IN) disable iff (RST_IN)
    !BUS_XFER_IN.valid |=> !TRIGGER_OUT)
    else $error("trigger without transfer");
  trig_outside_a: assert property ( // see RQ12
    @(posedge CLK_IN) disable iff (RST_IN)
    (trig_def[1:0] == dbt_pkg::MATCH_OUTSIDE &&
     BUS_XFER_IN.addr >= low_addr && BUS_XFER_IN.addr <= high_addr)
    |=> !TRIGGER_OUT)
    else $error("outside case hit inside");
  dir_compare_a: assert property ( // see RQ9
    @(posedge CLK_IN) disable iff (RST_IN)
    (trig_def[2] && !attr[15] && attr[7] != BUS_XFER_IN.dir_read)
    |=> !TRIGGER_OUT)
    else $error("direction ignored");
  dir_mask_a: assert property ( // see RQ5
    @(posedge CLK_IN) disable iff (RST_IN)
    (attr[15] && attr[14:8] == 7'h7f) |-> attr_hit)
    else $error("full mask not honoured");
  size_cmp_a: assert property ( // see RQ6
    @(posedge CLK_IN) disable iff (RST_IN)
    (attr[14:13] == 2'h0 && attr[6:5] != BUS_XFER_IN.size) |-> !attr_hit)
    else $error("size mismatch hit");
  shared_high_a: assert property ( // see RQ1
    @(posedge CLK_IN) disable iff (RST_IN)
    (mem_cmd && shared) |=> high_addr == $past(cmd_wdata))
    else $error("shared address not loaded");
  shared_data_a: assert property ( // see RQ2
    @(posedge CLK_IN) disable iff (RST_IN)
    (mem_wr && shared) |=> data_bkpt == $past(cmd_wdata))
    else $error("shared data not loaded");
  shared_attr_a: assert property ( // see RQ3
    @(posedge CLK_IN) disable iff (RST_IN)
    (mem_cmd && shared) |=> attr == $past(csel[15:0]))
    else $error("shared attributes not loaded");
  wb_ack_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    wb_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("ack timing");
  cover_inside_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    trig_def[1:0] == 2'h2 ##1 TRIGGER_OUT);
  cover_shared_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    mem_cmd && shared);
  cover_read_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    rd_cmd);
endmodule // dbt_trigger

// [verif/dbt_bus_model.sv]
// Local bus master model that issues single observed transfers
`timescale 1ns/1ps
module dbt_bus_model (
  // Clock
  input wire logic clk_in,
  // Transfer seen by the trigger
  output dbt_pkg::dbt_xfer_t xfer_out
);
  initial xfer_out = '0;

  // Optional idle cycle, one valid cycle, then an invalid cycle with all other fields inverted
  task automatic drive(input dbt_pkg::dbt_xfer_t x, input logic slow);
    dbt_pkg::dbt_xfer_t idle;
    idle = ~x;
    idle.valid = 1'b0;
    if (slow) begin
      @(posedge clk_in);
    end
    @(posedge clk_in);
    xfer_out <= x;
    @(posedge clk_in);
    xfer_out <= idle;
  endtask
endmodule // dbt_bus_model

// [verif/tb.sv]
// Self-checking bench for the breakpoint trigger and debug commands
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic trig;
  dbt_pkg::dbt_xfer_t xfer;
  dbt_pkg::dbt_xfer_t x;
  logic [31:0] seed = 32'h36f973b4;
  logic [31:0] q;
  logic [31:0] m_attr = {16'h0, dbt_pkg::ATTR_RESET};
  logic [31:0] m_low = 32'h0;
  logic [31:0] m_high = 32'h0;
  logic [31:0] m_data = 32'h0;
  logic [31:0] m_tdef = 32'h0;
  int err_count = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  dbt_trigger i_dbt_trigger (
    .CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .BUS_XFER_IN(xfer),
    .TRIGGER_OUT(trig));
  dbt_bus_model i_dbt_bus_model (.clk_in(clk), .xfer_out(xfer));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_trig(input logic e);
    n_tests++;
    if (trig !== e) begin
      err_count++;
      $display("mismatch trigger exp %b got %b", e, trig);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk_reg(nm, e, r);
  endtask

  task automatic set(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    case (a)
      dbt_pkg::OFF_ATTR: m_attr = {16'h0, d[15:0]};
      dbt_pkg::OFF_LOW: m_low = d;
      dbt_pkg::OFF_HIGH: m_high = d;
      dbt_pkg::OFF_TRIG: m_tdef = d;
      default: ;
    endcase
  endtask

  task automatic chk_all();
    rd(dbt_pkg::OFF_ATTR, m_attr, "attr");
    rd(dbt_pkg::OFF_LOW, m_low, "low");
    rd(dbt_pkg::OFF_HIGH, m_high, "high");
    rd(dbt_pkg::OFF_DATA, m_data, "data");
    rd(dbt_pkg::OFF_TRIG, m_tdef, "tdef");
  endtask

  task automatic cmd(input logic [15:0] op, input logic [31:0] s, d);
    wr(dbt_pkg::OFF_SEL, s);
    wr(dbt_pkg::OFF_WDATA, d);
    wr(dbt_pkg::OFF_CMD, {16'h8000, op});
    repeat (3) @(posedge clk);
  endtask

  function automatic logic exp_trig(input dbt_pkg::dbt_xfer_t t);
    logic hit;
    logic [7:0] b;
    case (m_tdef[1:0])
      2'h1: hit = t.addr == m_low;
      2'h2: hit = t.addr >= m_low && t.addr <= m_high;
      2'h3: hit = t.addr < m_low || t.addr > m_high;
      default: hit = 1'b0;
    endcase
    b = {t.dir_read, t.size, t.ttype, t.tmod};
    return t.valid && hit &&
      (!m_tdef[2] || ((b ^ m_attr[7:0]) & ~m_attr[15:8]) == 8'h00);
  endfunction

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_all();
    rd(8'h40, 32'h0, "unmapped");
    set(dbt_pkg::OFF_ATTR, 32'hffff_ffff);
    set(dbt_pkg::OFF_LOW, rnd());
    set(dbt_pkg::OFF_HIGH, rnd());
    chk_all();
    q = rnd();
    cmd(16'h2880, {20'h0, dbt_pkg::CSEL_LOW}, q);
    m_low = q;
    chk_all();
    cmd(16'h2880, {20'h0, dbt_pkg::CSEL_DATA}, ~q);
    m_data = ~q;
    chk_all();
    cmd(dbt_pkg::CMD_READ_CREG, {20'h0, dbt_pkg::CSEL_HIGH}, 32'h0);
    rd(dbt_pkg::OFF_RDATA, m_high, "creg");
    cmd(dbt_pkg::CMD_MEM_WRITE, 32'h0000_a5c3, 32'h1234_5678);
    chk_all();
    wr(dbt_pkg::OFF_CTRL, 32'h1);
    rd(dbt_pkg::OFF_CTRL, 32'h1, "ctrl");
    cmd(dbt_pkg::CMD_MEM_READ, 32'h0000_80a1, 32'hdead_0010);
    m_high = 32'hdead_0010;
    m_attr = 32'h0000_80a1;
    chk_all();
    cmd(dbt_pkg::CMD_MEM_WRITE, 32'h0000_7f22, 32'hcafe_0004);
    m_high = 32'hcafe_0004;
    m_attr = 32'h0000_7f22;
    m_data = 32'hcafe_0004;
    chk_all();
    cmd(16'h2880, {20'h0, dbt_pkg::CSEL_LOW}, 32'h0000_0100);
    m_low = 32'h0000_0100;
    m_data = 32'h0000_0100;
    chk_all();
    for (int i = 0; i < 200; i++) begin
      if (i % 25 == 0) begin
        q = rnd();
        set(dbt_pkg::OFF_LOW, {1'b0, q[30:0]});
        set(dbt_pkg::OFF_HIGH, m_low + {24'h0, q[7:0]});
        set(dbt_pkg::OFF_ATTR, rnd() & 32'h0000_ffff);
        set(dbt_pkg::OFF_TRIG, i / 25);
      end
      q = rnd();
      x.valid = 1'b1;
      case (q[2:0])
        3'h0: x.addr = m_low;
        3'h1: x.addr = m_high;
        3'h2: x.addr = m_low - 32'h1;
        3'h3: x.addr = m_high + 32'h1;
        default: x.addr = rnd();
      endcase
      {x.dir_read, x.size, x.ttype, x.tmod} = m_attr[7:0] ^
        (q[15:8] & q[23:16]);
      if (x.size == 2'h3) begin
        x.size = dbt_pkg::SIZE_WORD;
      end
      i_dbt_bus_model.drive(x, q[24]);
      #1;
      chk_trig(exp_trig(x));
    end
    test_done();
  end
endmodule // tb
